// ==== src/nsamo_consts.vh ====
// Constants for the non-secure access and mask override register block
`ifndef NSAMO_CONSTS_VH
`define NSAMO_CONSTS_VH
`define NSAMO_OPC1 3'h0
`define NSAMO_CRN 4'h1
`define NSAMO_CRM 4'h1
`define NSAMO_OPC2_ACCESS 3'h2
`define NSAMO_OPC2_OVERRIDE 3'h3
`define NSAMO_BIT_COPROC_ELEVEN_NS_PERMIT 11
`define NSAMO_BIT_COPROC_TEN_NS_PERMIT 10
`define NSAMO_BIT_ABORT 8
`define NSAMO_BIT_IRQ 7
`define NSAMO_BIT_FIQ 6
`define NSAMO_ACCESS_RESET 2'h0
`define NSAMO_OVERRIDE_RESET 3'h0
`define NSAMO_ZERO32 32'h00000000
`endif

// ==== src/nsamo_regs.v ====
// Non-secure coprocessor access control and exception mask override registers
//
// What this block does
// - Bit 11 of access control: reset 0 secure only, 1 grants non-secure coprocessor 11.
// - Bit 10 of access control: reset 0 secure only, 1 grants non-secure coprocessor 10.
// - Access control register decoded at opc1 0, c1, c1, opc2 2.
// - Mask override register accessible only from privileged modes.
// - Mask override register accessible only in secure state.
// - Non-secure, abort route set, bit 8 set: async abort taken despite mask.
// - Abort override ignored in secure state or when abort route clear.
// - Non-secure, IRQ route set, bit 7 set: IRQ taken despite mask.
// - IRQ override ignored in secure state or when IRQ route clear.
// - Non-secure, FIQ route set, bit 6 set: FIQ taken despite mask.
// - FIQ override ignored in secure state or when FIQ route clear.
// - Mask override register decoded at opc1 0, c1, c1, opc2 3.
`timescale 1ns/1ps
`include "nsamo_consts.vh"
module nsamo_regs (
	input wire clk,
	input wire rst_n,
	input wire cp_valid,
	input wire cp_write,
	input wire [2:0] cp_opc1,
	input wire [3:0] cp_crn,
	input wire [3:0] cp_crm,
	input wire [2:0] cp_opc2,
	input wire [31:0] cp_wdata,
	input wire cpu_privileged,
	input wire cpu_nonsecure,
	input wire external_abort_route_bit,
	input wire irq_route_bit,
	input wire fiq_route_bit,
	input wire async_abort_mask,
	input wire irq_mask_flag,
	input wire fiq_mask_flag,
	input wire async_abort_req,
	input wire irq_req,
	input wire fiq_req,
	output reg [31:0] cp_rdata,
	output reg cp_rvalid,
	output reg cp_undef,
	output reg coproc_eleven_ns_permit,
	output reg coproc_ten_ns_permit,
	output reg async_abort_take,
	output reg irq_take,
	output reg fiq_take
);
	localparam [1:0] ACCESS_RST = `NSAMO_ACCESS_RESET;
	localparam [2:0] OVERRIDE_RST = `NSAMO_OVERRIDE_RESET;

	// Override bits
	reg abort_mask_override_q;
	reg irq_mask_override_q;
	reg fiq_mask_override_q;

	// Answer path
	reg [31:0] rdata_d;
	reg rvalid_d;
	reg undef_d;
	wire [31:0] access_word;
	wire [31:0] override_word;

	// Decode
	wire opc_fields_hit;
	wire base_hit;
	wire hit_access;
	wire hit_override;
	wire override_ok;
	wire rd_access;
	wire rd_override;
	wire wr_access;
	wire wr_override;
	wire override_refused;

	// Write data fields
	wire wdata_coproc_eleven_ns_permit;
	wire wdata_coproc_ten_ns_permit;
	wire wdata_abort;
	wire wdata_irq;
	wire wdata_fiq;

	// Exception gating
	wire abort_override_on;
	wire irq_override_on;
	wire fiq_override_on;
	wire abort_take_d;
	wire irq_take_d;
	wire fiq_take_d;

	// Both registers share this encoding; only opc2 tells them apart
	function enc_match;
		input [2:0] opc1;
		input [3:0] crn;
		input [3:0] crm;
		begin
			enc_match = (opc1 == `NSAMO_OPC1) & (crn == `NSAMO_CRN) & (crm == `NSAMO_CRM);
		end
	endfunction

	// Only the non-secure world with routing to monitor sees an override
	function override_active;
		input nonsecure;
		input route;
		input ovr;
		begin
			override_active = nonsecure & route & ovr;
		end
	endfunction

	// A request passes when unmasked or when its override is live
	function gate_take;
		input req;
		input mask;
		input ovr_on;
		begin
			gate_take = req & (~mask | ovr_on);
		end
	endfunction

	// Reserved bits read as zero
	function [31:0] pack_access;
		input p11;
		input p10;
		begin
			pack_access = `NSAMO_ZERO32;
			pack_access[`NSAMO_BIT_COPROC_ELEVEN_NS_PERMIT] = p11;
			pack_access[`NSAMO_BIT_COPROC_TEN_NS_PERMIT] = p10;
		end
	endfunction

	// Reserved bits read as zero
	function [31:0] pack_override;
		input abort_mask_override;
		input irq_mask_override;
		input fmo;
		begin
			pack_override = `NSAMO_ZERO32;
			pack_override[`NSAMO_BIT_ABORT] = abort_mask_override;
			pack_override[`NSAMO_BIT_IRQ] = irq_mask_override;
			pack_override[`NSAMO_BIT_FIQ] = fmo;
		end
	endfunction

	// Instruction decode
	assign opc_fields_hit = enc_match(cp_opc1, cp_crn, cp_crm);
	assign base_hit = cp_valid & opc_fields_hit;
	assign hit_access = base_hit & (cp_opc2 == `NSAMO_OPC2_ACCESS);
	assign hit_override = base_hit & (cp_opc2 == `NSAMO_OPC2_OVERRIDE);
	assign override_ok = cpu_privileged & ~cpu_nonsecure;
	assign rd_access = hit_access & ~cp_write;
	assign rd_override = hit_override & ~cp_write & override_ok;
	assign wr_access = hit_access & cp_write;
	assign wr_override = hit_override & cp_write & override_ok;
	assign override_refused = hit_override & ~override_ok;

	// Reserved write bits are simply not picked up
	assign wdata_coproc_eleven_ns_permit = cp_wdata[`NSAMO_BIT_COPROC_ELEVEN_NS_PERMIT];
	assign wdata_coproc_ten_ns_permit = cp_wdata[`NSAMO_BIT_COPROC_TEN_NS_PERMIT];
	assign wdata_abort = cp_wdata[`NSAMO_BIT_ABORT];
	assign wdata_irq = cp_wdata[`NSAMO_BIT_IRQ];
	assign wdata_fiq = cp_wdata[`NSAMO_BIT_FIQ];

	assign access_word = pack_access(coproc_eleven_ns_permit, coproc_ten_ns_permit);
	assign override_word = pack_override(abort_mask_override_q, irq_mask_override_q, fiq_mask_override_q);

	// Virtual exceptions never pass through here, so the overrides cannot touch them
	assign abort_override_on = override_active(cpu_nonsecure, external_abort_route_bit, abort_mask_override_q);
	assign irq_override_on = override_active(cpu_nonsecure, irq_route_bit, irq_mask_override_q);
	assign fiq_override_on = override_active(cpu_nonsecure, fiq_route_bit, fiq_mask_override_q);
	assign abort_take_d = gate_take(async_abort_req, async_abort_mask, abort_override_on);
	assign irq_take_d = gate_take(irq_req, irq_mask_flag, irq_override_on);
	assign fiq_take_d = gate_take(fiq_req, fiq_mask_flag, fiq_override_on);

	// A refused or missed access returns all zeros
	always @* begin
		rdata_d = `NSAMO_ZERO32;
		rvalid_d = 1'b0;
		if (rd_access) begin
			rdata_d = access_word;
			rvalid_d = 1'b1;
		end else if (rd_override) begin
			rdata_d = override_word;
			rvalid_d = 1'b1;
		end
	end

	always @* begin
		undef_d = 1'b0;
		if (override_refused) begin
			undef_d = 1'b1;
		end
	end

	// Permission bits are writable from any state; gating their users lies outside this block
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			coproc_eleven_ns_permit <= ACCESS_RST[1];
		end else if (wr_access) begin
			coproc_eleven_ns_permit <= wdata_coproc_eleven_ns_permit;
		end else begin
			coproc_eleven_ns_permit <= coproc_eleven_ns_permit;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			coproc_ten_ns_permit <= ACCESS_RST[0];
		end else if (wr_access) begin
			coproc_ten_ns_permit <= wdata_coproc_ten_ns_permit;
		end else begin
			coproc_ten_ns_permit <= coproc_ten_ns_permit;
		end
	end

	// Override bits change only on a privileged secure write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_mask_override_q <= OVERRIDE_RST[2];
		end else if (wr_override) begin
			abort_mask_override_q <= wdata_abort;
		end else begin
			abort_mask_override_q <= abort_mask_override_q;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_override_q <= OVERRIDE_RST[1];
		end else if (wr_override) begin
			irq_mask_override_q <= wdata_irq;
		end else begin
			irq_mask_override_q <= irq_mask_override_q;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fiq_mask_override_q <= OVERRIDE_RST[0];
		end else if (wr_override) begin
			fiq_mask_override_q <= wdata_fiq;
		end else begin
			fiq_mask_override_q <= fiq_mask_override_q;
		end
	end

	// Read data stands one cycle, zero otherwise
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_rdata <= `NSAMO_ZERO32;
		end else begin
			cp_rdata <= rdata_d;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_rvalid <= 1'b0;
		end else begin
			cp_rvalid <= rvalid_d;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_undef <= 1'b0;
		end else begin
			cp_undef <= undef_d;
		end
	end

	// Takes are registered, so they trail the request by one cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			async_abort_take <= 1'b0;
		end else begin
			async_abort_take <= abort_take_d;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_take <= 1'b0;
		end else begin
			irq_take <= irq_take_d;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fiq_take <= 1'b0;
		end else begin
			fiq_take <= fiq_take_d;
		end
	end

	// Trade-off: one cycle of latency on every answer buys outputs straight from flops
endmodule

// ==== dv/nsamo_pipe.sv ====
// Pipeline model issuing one coprocessor instruction at a time
`timescale 1ns/1ps
module nsamo_pipe (input wire clk, output logic cp_valid = 0, cp_write = 0, cpu_privileged = 0, cpu_nonsecure = 0,
	output logic [2:0] cp_opc2 = 3'h0, output logic [31:0] cp_wdata = 32'h0);
	task issue(input w, input [2:0] op, input [31:0] dt, input [1:0] st);
		@(posedge clk);
		{cp_valid, cp_write, cp_opc2, cp_wdata, cpu_privileged, cpu_nonsecure} <= {1'b1, w, op, dt, st};
		@(posedge clk);
		cp_valid <= 0;
		// Fields flip once the instruction is gone, so a stale value cannot pass for a held one
		{cp_opc2, cp_wdata} <= ~{op, dt};
	endtask
endmodule

// ==== dv/nsamo_checker.sv ====
// Checker on register answers and irq gating
`timescale 1ns/1ps
`include "nsamo_consts.vh"
module nsamo_checker (input wire clk, rst_n, cp_valid, cp_write, cpu_privileged, cpu_nonsecure, irq_req, irq_take,
	irq_mask_flag, irq_route_bit, cp_rvalid, cp_undef, coproc_eleven_ns_permit, coproc_ten_ns_permit,
	input wire [2:0] cp_opc1, cp_opc2, input wire [3:0] cp_crn, cp_crm, input wire [31:0] cp_wdata, cp_rdata);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire e = cp_valid && {cp_opc1, cp_crn, cp_crm} == {`NSAMO_OPC1, `NSAMO_CRN, `NSAMO_CRM};
	wire a = e && cp_opc2 == `NSAMO_OPC2_ACCESS, o = e && cp_opc2 == `NSAMO_OPC2_OVERRIDE;
	wire ar = a && !cp_write, aw = a && cp_write, bad = o && !(cpu_privileged && !cpu_nonsecure), nm = !(a || o);
	wire orr = o && !bad && !cp_write, ig = irq_mask_flag && !(cpu_nonsecure && irq_route_bit);
	wire oc = irq_req && !irq_mask_flag;
	wire [1:0] wb = cp_wdata[11:10], pm = {coproc_eleven_ns_permit, coproc_ten_ns_permit};
	property p_i; $past(ig) |-> !irq_take; endproperty a_i: assert property (p_i) else $error("irq past mask");
	property p_q; !$past(irq_req) |-> !irq_take; endproperty a_q: assert property (p_q) else $error("stray irq");
	property p_c; $past(oc) |-> irq_take; endproperty a_c: assert property (p_c) else $error("irq lost");
	property p_u; $past(bad) |-> cp_undef && !cp_rvalid; endproperty a_u: assert property (p_u) else $error("undef");
	property p_n; $past(nm) |-> !cp_rvalid && !cp_undef; endproperty a_n: assert property (p_n) else $error("answer");
	property p_w; $past(aw) |-> pm == $past(wb); endproperty a_w: assert property (p_w) else $error("permit");
	property p_o; $past(orr) |-> cp_rvalid && cp_rdata[31:9] == 23'h0 && cp_rdata[5:0] == 6'h0; endproperty
	a_o: assert property (p_o) else $error("override read");
	property p_r; $past(ar) |-> cp_rvalid && cp_rdata == {20'h0, pm, 10'h0}; endproperty
	a_r: assert property (p_r) else $error("access read");
	c_u: cover property (cp_undef);
	c_r: cover property (cp_rvalid && cp_rdata != 32'h0);
	c_i: cover property (irq_take && $past(irq_mask_flag));
endmodule
bind nsamo_regs nsamo_checker u_chk (.*);

// ==== dv/testbench.sv ====
// Self-checking bench for register traffic and exception gating
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst_n = 0;
	logic [2:0] cp_opc1 = 3'h0, ms = 3'h0, rt = 3'h0, rq = 3'h0, ov;
	logic [3:0] cp_crn = 4'h1, cp_crm = 4'h1;
	logic [31:0] s = 32'h00013721, d;
	logic [33:0] q[$];
	wire cp_valid, cp_write, cpu_privileged, cpu_nonsecure, cp_rvalid, cp_undef, coproc_eleven_ns_permit, coproc_ten_ns_permit;
	wire [2:0] cp_opc2, tk;
	wire [31:0] cp_wdata, cp_rdata;
	int n_errors = 0, n_compared = 0;
	nsamo_pipe P (.*);
	nsamo_regs DUT (.*, .external_abort_route_bit(rt[2]), .irq_route_bit(rt[1]), .fiq_route_bit(rt[0]),
		.async_abort_mask(ms[2]), .irq_mask_flag(ms[1]), .fiq_mask_flag(ms[0]), .async_abort_req(rq[2]), .irq_req(rq[1]),
		.fiq_req(rq[0]), .async_abort_take(tk[2]), .irq_take(tk[1]), .fiq_take(tk[0]));
	always #12.5 clk = ~clk;
	function automatic [31:0] xs();
		s ^= s << 13; s ^= s >> 17; s ^= s << 5;
		return s;
	endfunction
	task chk(input string n, input [33:0] e, g);
		n_compared++;
		if (e !== g) begin n_errors++; $display("wrong value %s expected %h seen %h", n, e, g); end
	endtask
	// Expected answers are queued at issue; an empty queue makes any answer a stray one
	always @(posedge clk) if (cp_rvalid | cp_undef) chk("answer", q.size() ? q.pop_front() : 34'h0,
		{cp_rvalid, cp_undef, cp_rdata});
	task acc(input w, input [2:0] op, input [31:0] dt, input [1:0] st, input [33:0] e);
		if (e != 34'h0) q.push_back(e);
		P.issue(w, op, dt, st);
	endtask
	task summarize();
		// An expected answer that never came counts as a mismatch
		if (q.size() != 0) n_errors++;
		if (n_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin #80000; n_errors++; summarize(); end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		acc(0, 3'h2, 0, 2'h2, 34'h200000000);
		acc(0, 3'h3, 0, 2'h2, 34'h200000000);
		repeat (2) begin
			d = xs();
			acc(1, 3'h2, d, 2'h3, 0);
			acc(1, 3'h3, d, 2'h2, 0);
			acc(1, 3'h3, ~d, 2'h0, 34'h100000000);
			acc(0, 3'h3, 0, 2'h3, 34'h100000000);
			acc(0, 3'h4, 0, 2'h2, 0);
			acc(0, 3'h2, 0, 2'h1, {2'h2, d & 32'h00000c00});
			acc(0, 3'h3, 0, 2'h2, {2'h2, d & 32'h000001c0});
			ov = d[8:6];
			repeat (150) begin
				@(posedge clk);
				d = xs();
				{rq, ms, rt} <= d[9:1];
				P.cpu_nonsecure <= d[0];
				@(posedge clk);
				#1 chk("take", {31'h0, tk}, {31'h0, d[9:7] & (~d[6:4] | {3{d[0]}} & d[3:1] & ov)});
			end
		end
		summarize();
	end
endmodule
